// ---- common/gpro_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface gpro_if
  import gpro_pkg::*;
#(
  parameter int AW = GPRO_AW,
  parameter int DW = GPRO_DW
);
  // request channel, master to target
  logic req_valid;
  logic req_ready;
  gpro_cmd_t req_cmd;
  logic [AW-1:0] req_addr;
  logic [DW-1:0] req_wdata;
  // answer channel, target to master
  logic ret_valid;
  logic ret_ready;
  gpro_kind_t ret_kind;
  logic [DW-1:0] ret_data;

  modport target (
    input req_valid, req_cmd, req_addr, req_wdata, ret_ready,
    output req_ready, ret_valid, ret_kind, ret_data
  );
  modport master (
    output req_valid, req_cmd, req_addr, req_wdata, ret_ready,
    input req_ready, ret_valid, ret_kind, ret_data
  );
endinterface
`default_nettype wire

// ---- common/gpro_pkg.sv ----
`default_nettype none
package gpro_pkg;

  // ****************************************
  // widths, depths and counts
  // ****************************************
  localparam int GPRO_AW = 10; // word address width of the target memory
  localparam int GPRO_DW = 64; // one quadword per transfer
  localparam int GPRO_WQ_DEPTH = 32; // posted low-priority write buffer
  localparam int GPRO_RQ_DEPTH = 8; // low-priority read and flush queue
  localparam int GPRO_HQ_DEPTH = 4; // high-priority read queue
  localparam int GPRO_CNT_W = 8; // sequence counters, modulo arithmetic

  // ****************************************
  // reset values
  // ****************************************
  localparam logic GPRO_READY_RST = 1'b0;
  localparam logic GPRO_VALID_RST = 1'b0;

  // ****************************************
  // commands and answer kinds
  // ****************************************
  typedef enum logic [2:0] {
    GPRO_LP_READ,
    GPRO_LP_WRITE,
    GPRO_HP_READ,
    GPRO_HP_WRITE,
    GPRO_FLUSH,
    GPRO_FENCE,
    GPRO_CONV_READ,
    GPRO_CONV_WRITE
  } gpro_cmd_t;

  typedef enum logic [1:0] {
    GPRO_RET_LP,
    GPRO_RET_HP,
    GPRO_RET_CONV
  } gpro_kind_t;

  // low-priority reads and flushes share one ordered queue
  function automatic logic gpro_is_lp_read(input gpro_cmd_t cmd);
    return (cmd == GPRO_LP_READ) || (cmd == GPRO_FLUSH);
  endfunction

endpackage
`default_nettype wire

// ---- logic/gpro_master.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// graphics controller master end
// ****************************************
module gpro_master
  import gpro_pkg::*;
#(
  parameter int AW = GPRO_AW,
  parameter int DW = GPRO_DW,
  parameter int CW = GPRO_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // port link
  gpro_if.master link,
  // user command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire gpro_cmd_t cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_wdata,
  input wire logic cmd_keep_old,
  // user answer side
  output logic rsp_valid,
  output gpro_kind_t rsp_kind,
  output logic [DW-1:0] rsp_data
);
  if (CW < 2) begin : g_check
    $error("gpro_master: counter width below 2");
  end

  typedef enum {GPRO_M_IDLE, GPRO_M_FENCE, GPRO_M_SEND} gpro_mstate_t;

  gpro_mstate_t state, next_state;
  logic req_valid, next_req_valid, next_cmd_ready, ret_ready;
  gpro_cmd_t req_cmd, next_req_cmd, held_cmd, next_held_cmd;
  logic [AW-1:0] req_addr, next_req_addr;
  logic [DW-1:0] req_wdata, next_req_wdata;
  logic [CW-1:0] lp_out, next_lp_out;
  logic next_rsp_valid, taken, ret_take;

  assign taken = req_valid && link.req_ready;
  assign ret_take = link.ret_valid && ret_ready;

  // ****************************************
  // request sequencer
  // ****************************************
  // old data wanted: a fence goes ahead of the write instead of waiting
  // for read data, so the master never holds the write back behind a read
  always_comb begin
    next_state = state;
    next_req_valid = req_valid;
    next_req_cmd = req_cmd;
    next_req_addr = req_addr;
    next_req_wdata = req_wdata;
    next_held_cmd = held_cmd;
    case (state)
      GPRO_M_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_req_valid = 1'b1;
          next_req_addr = cmd_addr;
          next_req_wdata = cmd_wdata;
          next_held_cmd = cmd_op;
          if (cmd_op == GPRO_LP_WRITE && cmd_keep_old && lp_out != '0) begin
            next_req_cmd = GPRO_FENCE;
            next_state = GPRO_M_FENCE;
          end else begin
            next_req_cmd = cmd_op;
            next_state = GPRO_M_SEND;
          end
        end
      end
      GPRO_M_FENCE: begin
        if (taken) begin
          next_req_cmd = held_cmd;
          next_state = GPRO_M_SEND;
        end
      end
      GPRO_M_SEND: begin
        if (taken) begin
          next_req_valid = 1'b0;
          next_state = GPRO_M_IDLE;
        end
      end
      default: begin
        next_req_valid = 1'b0;
        next_state = GPRO_M_IDLE;
      end
    endcase
    next_cmd_ready = (next_state == GPRO_M_IDLE);
  end

  // outstanding low-priority reads decide whether a fence is needed
  always_comb begin
    next_lp_out = lp_out;
    if (taken && state == GPRO_M_SEND && gpro_is_lp_read(req_cmd) && !(ret_take && link.ret_kind == GPRO_RET_LP)) begin
      next_lp_out = lp_out + 1'b1;
    end else if (!(taken && state == GPRO_M_SEND && gpro_is_lp_read(req_cmd)) && ret_take &&
                 link.ret_kind == GPRO_RET_LP && lp_out != '0) begin
      next_lp_out = lp_out - 1'b1;
    end
    next_rsp_valid = ret_take;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= GPRO_M_IDLE;
      req_valid <= GPRO_VALID_RST;
      req_cmd <= GPRO_LP_READ;
      req_addr <= '0;
      req_wdata <= '0;
      held_cmd <= GPRO_LP_READ;
      cmd_ready <= GPRO_READY_RST;
      lp_out <= '0;
      ret_ready <= GPRO_READY_RST;
      rsp_valid <= 1'b0;
      rsp_kind <= GPRO_RET_LP;
      rsp_data <= '0;
    end else begin
      state <= next_state;
      req_valid <= next_req_valid;
      req_cmd <= next_req_cmd;
      req_addr <= next_req_addr;
      req_wdata <= next_req_wdata;
      held_cmd <= next_held_cmd;
      cmd_ready <= next_cmd_ready;
      lp_out <= next_lp_out;
      ret_ready <= 1'b1;
      rsp_valid <= next_rsp_valid;
      rsp_kind <= link.ret_kind;
      rsp_data <= link.ret_data;
    end
  end

  assign link.req_valid = req_valid;
  assign link.req_cmd = req_cmd;
  assign link.req_addr = req_addr;
  assign link.req_wdata = req_wdata;
  assign link.ret_ready = ret_ready;
endmodule
`default_nettype wire

// ---- logic/gpro_target.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// generic fifo
// ****************************************
module gpro_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("gpro_fifo: depth below 2 or empty width");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [PW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers wrap at depth, so depth need not be a power of two
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage carries no reset, only the pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

// ****************************************
// core-logic target
// ****************************************
module gpro_target
  import gpro_pkg::*;
#(
  parameter int AW = GPRO_AW,
  parameter int DW = GPRO_DW,
  parameter int WQ_DEPTH = GPRO_WQ_DEPTH,
  parameter int RQ_DEPTH = GPRO_RQ_DEPTH,
  parameter int HQ_DEPTH = GPRO_HQ_DEPTH,
  parameter int CW = GPRO_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // port link
  gpro_if.target link,
  // memory commit trace
  output logic commit_valid,
  output logic commit_hp,
  output logic [AW-1:0] commit_addr,
  output logic [DW-1:0] commit_data,
  // flush completion
  output logic flush_done
);
  localparam int WQW = AW + DW + CW;
  localparam int RQW = 1 + AW + CW;

  // counters must tell outstanding work apart after wrapping
  if (WQ_DEPTH + RQ_DEPTH + 2 >= (1 << (CW - 1))) begin : g_check
    $error("gpro_target: sequence counters too narrow for queue depths");
  end

  typedef enum {GPRO_G_NONE, GPRO_G_HPW, GPRO_G_HPR, GPRO_G_CONV, GPRO_G_LPR, GPRO_G_LPW} gpro_gnt_t;

  logic [DW-1:0] mem [2**AW];
  gpro_gnt_t gnt;

  // ****************************************
  // intake register
  // ****************************************
  logic req_ready, next_req_ready;
  logic in_valid, next_in_valid;
  gpro_cmd_t in_cmd, next_in_cmd;
  logic [AW-1:0] in_addr, next_in_addr;
  logic [DW-1:0] in_wdata, next_in_wdata;
  logic accept, dispatch;
  logic wq_in_ready, rq_in_ready, hq_in_ready;

  assign accept = link.req_valid && req_ready;
  assign link.req_ready = req_ready;

  // one request at a time leaves intake, so conventional ops stay serial
  always_comb begin
    case (in_cmd)
      GPRO_LP_WRITE: dispatch = in_valid && wq_in_ready;
      GPRO_LP_READ, GPRO_FLUSH: dispatch = in_valid && rq_in_ready;
      GPRO_HP_READ: dispatch = in_valid && hq_in_ready;
      GPRO_FENCE: dispatch = in_valid;
      GPRO_HP_WRITE: dispatch = (gnt == GPRO_G_HPW);
      default: dispatch = (gnt == GPRO_G_CONV);
    endcase
    next_in_valid = (in_valid && !dispatch) || accept;
    next_req_ready = !next_in_valid;
    next_in_cmd = accept ? link.req_cmd : in_cmd;
    next_in_addr = accept ? link.req_addr : in_addr;
    next_in_wdata = accept ? link.req_wdata : in_wdata;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= GPRO_READY_RST;
      in_valid <= GPRO_VALID_RST;
      in_cmd <= GPRO_LP_READ;
      in_addr <= '0;
      in_wdata <= '0;
    end else begin
      req_ready <= next_req_ready;
      in_valid <= next_in_valid;
      in_cmd <= next_in_cmd;
      in_addr <= next_in_addr;
      in_wdata <= next_in_wdata;
    end
  end

  // ****************************************
  // ordering queues and sequence counters
  // ****************************************
  logic [CW-1:0] wr_enq, wr_done, rd_enq, rd_done, fence_mark;
  logic [CW-1:0] next_wr_enq, next_wr_done, next_rd_enq, next_rd_done, next_fence_mark;
  logic wq_out_valid, rq_out_valid, hq_out_valid;
  logic [WQW-1:0] wq_out;
  logic [RQW-1:0] rq_out;
  logic [AW-1:0] hq_out;
  logic [CW-1:0] w_mark, r_mark, rd_gap;
  logic r_flush, wr_ok, rd_ok, ret_free;

  // posted writes: fills when memory is busy with higher-priority work
  gpro_fifo #(.WIDTH(WQW), .DEPTH(WQ_DEPTH)) u_wq (
    .clk(clk), .rst_b(rst_b),
    .in_valid(in_valid && in_cmd == GPRO_LP_WRITE), .in_ready(wq_in_ready),
    .in_data({in_addr, in_wdata, fence_mark}),
    .out_valid(wq_out_valid), .out_ready(gnt == GPRO_G_LPW), .out_data(wq_out)
  );
  // reads and flushes carry the write count seen at enqueue
  gpro_fifo #(.WIDTH(RQW), .DEPTH(RQ_DEPTH)) u_rq (
    .clk(clk), .rst_b(rst_b),
    .in_valid(in_valid && gpro_is_lp_read(in_cmd)), .in_ready(rq_in_ready),
    .in_data({in_cmd == GPRO_FLUSH, in_addr, wr_enq}),
    .out_valid(rq_out_valid), .out_ready(gnt == GPRO_G_LPR), .out_data(rq_out)
  );
  // high-priority reads are ordered only among themselves
  gpro_fifo #(.WIDTH(AW), .DEPTH(HQ_DEPTH)) u_hq (
    .clk(clk), .rst_b(rst_b),
    .in_valid(in_valid && in_cmd == GPRO_HP_READ), .in_ready(hq_in_ready),
    .in_data(in_addr),
    .out_valid(hq_out_valid), .out_ready(gnt == GPRO_G_HPR), .out_data(hq_out)
  );

  assign w_mark = wq_out[CW-1:0];
  assign r_mark = rq_out[CW-1:0];
  assign r_flush = rq_out[RQW-1];
  assign rd_gap = rd_done - w_mark;
  assign wr_ok = !rd_gap[CW-1];
  assign rd_ok = (wr_done == r_mark);
  assign ret_free = !link.ret_valid || link.ret_ready;

  // memory arbitration, one access per cycle
  always_comb begin
    if (in_valid && in_cmd == GPRO_HP_WRITE) begin
      gnt = GPRO_G_HPW;
    end else if (hq_out_valid && ret_free) begin
      gnt = GPRO_G_HPR;
    end else if (in_valid && (in_cmd == GPRO_CONV_WRITE || (in_cmd == GPRO_CONV_READ && ret_free))) begin
      gnt = GPRO_G_CONV;
    end else if (rq_out_valid && rd_ok && ret_free) begin
      gnt = GPRO_G_LPR;
    end else if (wq_out_valid && wr_ok) begin
      gnt = GPRO_G_LPW;
    end else begin
      gnt = GPRO_G_NONE;
    end
  end

  // fence only snapshots the read count, never enters a queue
  always_comb begin
    next_wr_enq = wr_enq;
    next_rd_enq = rd_enq;
    next_wr_done = wr_done;
    next_rd_done = rd_done;
    next_fence_mark = fence_mark;
    if (dispatch && in_cmd == GPRO_LP_WRITE) begin
      next_wr_enq = wr_enq + 1'b1;
    end
    if (dispatch && gpro_is_lp_read(in_cmd)) begin
      next_rd_enq = rd_enq + 1'b1;
    end
    // a met mark trails the done count, else the modulo gap wraps and stalls writes
    if (dispatch && in_cmd == GPRO_FENCE) begin
      next_fence_mark = rd_enq;
    end else if (fence_mark == rd_done) begin
      next_fence_mark = next_rd_done;
    end
    if (gnt == GPRO_G_LPW) begin
      next_wr_done = wr_done + 1'b1;
    end
    if (gnt == GPRO_G_LPR) begin
      next_rd_done = rd_done + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_enq <= '0;
      rd_enq <= '0;
      wr_done <= '0;
      rd_done <= '0;
      fence_mark <= '0;
    end else begin
      wr_enq <= next_wr_enq;
      rd_enq <= next_rd_enq;
      wr_done <= next_wr_done;
      rd_done <= next_rd_done;
      fence_mark <= next_fence_mark;
    end
  end

  // ****************************************
  // memory access and answer stage
  // ****************************************
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [DW-1:0] mem_wdata;
  logic ret_valid, next_ret_valid, next_commit_valid, next_commit_hp, next_flush_done;
  gpro_kind_t ret_kind, next_ret_kind;
  logic [DW-1:0] ret_data, next_ret_data;

  always_comb begin
    mem_we = (gnt == GPRO_G_HPW) || (gnt == GPRO_G_LPW) || (gnt == GPRO_G_CONV && in_cmd == GPRO_CONV_WRITE);
    mem_waddr = (gnt == GPRO_G_LPW) ? wq_out[WQW-1 -: AW] : in_addr;
    mem_wdata = (gnt == GPRO_G_LPW) ? wq_out[CW +: DW] : in_wdata;
    next_commit_valid = mem_we;
    next_commit_hp = (gnt == GPRO_G_HPW);
    next_flush_done = (gnt == GPRO_G_LPR) && r_flush;
    next_ret_valid = ret_valid && !link.ret_ready;
    next_ret_kind = ret_kind;
    next_ret_data = ret_data;
    // data is picked here and frozen in the answer register
    case (gnt)
      GPRO_G_HPR: begin
        next_ret_valid = 1'b1;
        next_ret_kind = GPRO_RET_HP;
        next_ret_data = mem[hq_out];
      end
      GPRO_G_CONV: begin
        if (in_cmd == GPRO_CONV_READ) begin
          next_ret_valid = 1'b1;
          next_ret_kind = GPRO_RET_CONV;
          next_ret_data = mem[in_addr];
        end
      end
      GPRO_G_LPR: begin
        next_ret_valid = 1'b1;
        next_ret_kind = GPRO_RET_LP;
        next_ret_data = r_flush ? '0 : mem[rq_out[CW +: AW]];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ret_valid <= GPRO_VALID_RST;
      ret_kind <= GPRO_RET_LP;
      ret_data <= '0;
      commit_valid <= 1'b0;
      commit_hp <= 1'b0;
      commit_addr <= '0;
      commit_data <= '0;
      flush_done <= 1'b0;
    end else begin
      ret_valid <= next_ret_valid;
      ret_kind <= next_ret_kind;
      ret_data <= next_ret_data;
      commit_valid <= next_commit_valid;
      commit_hp <= next_commit_hp;
      commit_addr <= mem_waddr;
      commit_data <= mem_wdata;
      flush_done <= next_flush_done;
    end
  end

  assign link.ret_valid = ret_valid;
  assign link.ret_kind = ret_kind;
  assign link.ret_data = ret_data;
endmodule
`default_nettype wire

// ---- verification/gpro_link_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// link ordering checker
// ****************************************
module gpro_link_check
  import gpro_pkg::*;
#(
  parameter int AW = GPRO_AW,
  parameter int DW = GPRO_DW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request channel
  input wire logic req_valid,
  input wire logic req_ready,
  input wire gpro_cmd_t req_cmd,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  // answer channel
  input wire logic ret_valid,
  input wire logic ret_ready,
  input wire gpro_kind_t ret_kind
);
  logic take;
  logic rtake;
  logic [7:0] lp_out;
  logic [7:0] hp_out;
  logic [7:0] cv_out;
  logic [7:0] next_lp_out;
  logic [7:0] next_hp_out;
  logic [7:0] next_cv_out;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  assign take = req_valid && req_ready;
  assign rtake = ret_valid && ret_ready;
  // outstanding reads per stream; an answer with none open means a lost order
  always_comb begin
    next_lp_out = lp_out + 8'(take && (req_cmd == GPRO_LP_READ || req_cmd == GPRO_FLUSH))
      - 8'(rtake && ret_kind == GPRO_RET_LP);
    next_hp_out = hp_out + 8'(take && req_cmd == GPRO_HP_READ) - 8'(rtake && ret_kind == GPRO_RET_HP);
    next_cv_out = cv_out + 8'(take && req_cmd == GPRO_CONV_READ) - 8'(rtake && ret_kind == GPRO_RET_CONV);
  end
  // counters only register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lp_out <= 8'h00;
      hp_out <= 8'h00;
      cv_out <= 8'h00;
    end else begin
      lp_out <= next_lp_out;
      hp_out <= next_hp_out;
      cv_out <= next_cv_out;
    end
  end
  property p_req_hold;
    req_valid && !req_ready |=> req_valid && $stable(req_cmd) && $stable(req_addr) && $stable(req_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before it was taken");
  property p_fence_free;
    take && req_cmd == GPRO_FENCE |-> ##[2:4] req_ready;
  endproperty
  a_fence_free: assert property (p_fence_free) else $error("fence held the intake");
  property p_hp_prompt;
    take && req_cmd == GPRO_HP_READ |-> ##[2:60] (rtake && ret_kind == GPRO_RET_HP);
  endproperty
  a_hp_prompt: assert property (p_hp_prompt) else $error("high priority read not answered");
  property p_flush_ans;
    take && req_cmd == GPRO_FLUSH |-> ##[2:400] (rtake && ret_kind == GPRO_RET_LP);
  endproperty
  a_flush_ans: assert property (p_flush_ans) else $error("flush got no answer");
  property p_lp_order;
    rtake && ret_kind == GPRO_RET_LP |-> lp_out != 8'h00;
  endproperty
  a_lp_order: assert property (p_lp_order) else $error("low priority answer without request");
  property p_hp_order;
    rtake && ret_kind == GPRO_RET_HP |-> hp_out != 8'h00;
  endproperty
  a_hp_order: assert property (p_hp_order) else $error("high priority answer without request");
  property p_cv_order;
    rtake && ret_kind == GPRO_RET_CONV |-> cv_out != 8'h00;
  endproperty
  a_cv_order: assert property (p_cv_order) else $error("conventional answer without request");
  property p_ret_accept;
    ret_valid |-> ret_ready;
  endproperty
  a_ret_accept: assert property (p_ret_accept) else $error("master refused read data");
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// both ends joined, reference model in the bench
// ****************************************
module testbench;
  import gpro_pkg::*;
  typedef struct {int a; int i; int need; bit fl; logic [63:0] d;} gpro_exp_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid, cmd_ready, cmd_keep_old, rsp_valid, commit_valid, commit_hp, flush_done;
  gpro_cmd_t cmd_op, op;
  gpro_kind_t rsp_kind;
  logic [GPRO_AW-1:0] cmd_addr, commit_addr;
  logic [63:0] cmd_wdata, rsp_data, commit_data;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int lp_iss = 0, lp_ans = 0, wr_iss = 0, commits = 0, fl_done = 0, fl_ans = 0, ad, n;
  logic [63:0] hist [1024][$];
  gpro_exp_t lp_q[$], hp_q[$], cv_q[$], lpw_q[$], hpw_q[$], cvw_q[$];
  gpro_exp_t e, r, w;

  gpro_if u_gpro_if ();
  gpro_master u_gpro_master (.clk(clk), .rst_b(rst_b), .link(u_gpro_if.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_keep_old(cmd_keep_old), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_data(rsp_data));
  gpro_target u_gpro_target (.clk(clk), .rst_b(rst_b), .link(u_gpro_if.target), .commit_valid(commit_valid),
    .commit_hp(commit_hp), .commit_addr(commit_addr), .commit_data(commit_data), .flush_done(flush_done));
  gpro_link_check u_gpro_link_check (.clk(clk), .rst_b(rst_b), .req_valid(u_gpro_if.req_valid),
    .req_ready(u_gpro_if.req_ready), .req_cmd(u_gpro_if.req_cmd), .req_addr(u_gpro_if.req_addr),
    .req_wdata(u_gpro_if.req_wdata), .ret_valid(u_gpro_if.ret_valid), .ret_ready(u_gpro_if.ret_ready),
    .ret_kind(u_gpro_if.ret_kind));

  always #4 clk = ~clk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a read may see its issue-time value or any later write that passed it
  task automatic check_read(input logic [63:0] got, input gpro_exp_t x);
    logic [63:0] pick;
    pick = hist[x.a][x.i];
    for (int k = x.i; k < hist[x.a].size(); k++) if (hist[x.a][k] === got) pick = got;
    check(got, pick);
  endtask

  // one user command, model updated at the edge that takes it
  task automatic send(input gpro_cmd_t c, input int a, input logic k);
    logic [63:0] d;
    d = {$urandom, $urandom};
    @(posedge clk);
    cmd_op <= c;
    cmd_addr <= GPRO_AW'(a);
    cmd_wdata <= d;
    cmd_keep_old <= k;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    if (c == GPRO_LP_WRITE || c == GPRO_HP_WRITE || c == GPRO_CONV_WRITE) hist[a].push_back(d);
    e = '{a, hist[a].size() - 1, 0, 1'b0, d};
    case (c)
      GPRO_LP_READ: begin lp_q.push_back(e); lp_iss++; end
      GPRO_FLUSH: begin e.fl = 1'b1; e.need = wr_iss; lp_q.push_back(e); lp_iss++; end
      GPRO_HP_READ: hp_q.push_back(e);
      GPRO_CONV_READ: cv_q.push_back(e);
      GPRO_LP_WRITE: begin e.need = k ? lp_iss : 0; lpw_q.push_back(e); wr_iss++; end
      GPRO_HP_WRITE: begin hpw_q.push_back(e); wr_iss++; end
      GPRO_CONV_WRITE: cvw_q.push_back(e);
      default: ;
    endcase
  endtask

  // answers and commit trace against the model; hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      end_sim();
    end
    if (flush_done === 1'b1) fl_done++;
    if (rsp_valid === 1'b1) begin
      if (rsp_kind === GPRO_RET_LP) begin
        r = lp_q.pop_front();
        lp_ans++;
        if (r.fl) begin
          check(rsp_data, 64'h0);
          check(commits >= r.need, 64'h1);
          fl_ans++;
          check(fl_done, fl_ans);
        end else check_read(rsp_data, r);
      end else if (rsp_kind === GPRO_RET_HP) check_read(rsp_data, hp_q.pop_front());
      else check_read(rsp_data, cv_q.pop_front());
    end
    if (commit_valid === 1'b1) begin
      if (commit_hp === 1'b1) w = hpw_q.pop_front();
      else if (commit_addr >= 10'h200) w = cvw_q.pop_front();
      else begin
        w = lpw_q.pop_front();
        check(lp_ans >= w.need, 64'h1);
      end
      if (commit_addr < 10'h200) commits++;
      check(commit_addr, w.a);
      check(commit_data, w.d);
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cmd_valid = 1'b0;
    cmd_op = GPRO_LP_READ;
    cmd_addr = '0;
    cmd_wdata = '0;
    cmd_keep_old = 1'b0;
    void'($urandom(32'hf837));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // preload every address so no read meets unwritten memory
    for (int a = 0; a < 16; a++) send(GPRO_LP_WRITE, a, 1'b0);
    for (int a = 0; a < 8; a++) begin
      send(GPRO_HP_WRITE, 10'h100 + a, 1'b0);
      send(GPRO_CONV_WRITE, 10'h200 + a, 1'b0);
    end
    // small address set so reads and writes collide often
    for (int t = 0; t < 400; t++) begin
      op = gpro_cmd_t'($urandom % 8);
      if (op == GPRO_HP_READ || op == GPRO_HP_WRITE) ad = 10'h100 + $urandom % 8;
      else if (op == GPRO_CONV_READ || op == GPRO_CONV_WRITE) ad = 10'h200 + $urandom % 8;
      else ad = $urandom % 16;
      repeat (op == GPRO_FENCE ? 3 : 1) send(op, ad, 1'($urandom % 2));
    end
    // burst longer than the posted write queue, every write must commit in order
    repeat (100) @(posedge clk);
    n = commits;
    for (int k = 0; k < 40; k++) send(GPRO_LP_WRITE, k % 16, 1'($urandom % 2));
    repeat (100) @(posedge clk);
    check(commits - n, 40);
    check(lpw_q.size(), 0);
    // read the burst back, only the newest values are legal now
    for (int a = 0; a < 16; a++) send(GPRO_LP_READ, a, 1'b0);
    repeat (200) @(posedge clk);
    check(u_gpro_if.ret_valid, 64'h0);
    check(lp_q.size() + hp_q.size() + cv_q.size() + lpw_q.size() + hpw_q.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
